// ### hdl/gpio7_pin_map.vh
// Purpose: Offsets, field positions, reset values and codes for the pin control block
// Assumes: Included by the pin control module, its assertions and its test bench
// Notes: Register offsets are indexes on the plain register port
`ifndef GPIO7_PIN_MAP_VH
`define GPIO7_PIN_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define GPIO7_PIN_CONFIG_ADDR 16'h403E
`define IRQ_STATUS_ADDR 16'h4040
`define IRQ_MASK_ADDR 16'h4041
`define PIN_STATE_ADDR 16'h4042
`define OUT_VALUE_ADDR 16'h4043

// ****************************************
// Config fields
// ****************************************
`define DIR_BIT 15
`define PULL_HI 14
`define PULL_LO 13
`define IRQ_MODE_BIT 12
`define DOMAIN_BIT 11
`define POL_BIT 10
`define OD_BIT 9
`define ENA_BIT 7
`define FN_HI 3
`define FN_LO 0
`define CONFIG_RESET 16'hA400
`define CONFIG_WMASK 16'hFE8F

// ****************************************
// Pull encodings
// ****************************************
`define PULL_NONE 2'h0
`define PULL_DOWN 2'h1
`define PULL_UP 2'h2

// ****************************************
// Interrupt status bits
// ****************************************
`define IRQ_EDGE_BIT 0
`define IRQ_WDOG_BIT 1
`define IRQ_WIDTH 2

// ****************************************
// Timing
// ****************************************
`define CLK_HZ 125000000
`define OSC32_HZ 32768
`define PWRCLK_HZ 2000000
`define PWRCLK_HALF (`CLK_HZ / (2 * `PWRCLK_HZ))
`define LONG_DEBOUNCE_CYCLES 125000

`endif

// ### hdl/gpio7_pin_control.v
// Purpose: Configuration and function routing for one general-purpose pin
// Assumes: Single clock mclk at 125 MHz, synchronous active-high reset
// Notes: Register port gives read data in the cycle after the read strobe
//
// Summary of operation
// RL1: Direction bit 0 makes the pin an output, 1 an input; resets to 1.
// RL2: Pull field 00 none, 01 pull-down, 10 pull-up, 11 reserved; resets 01.
// RL3: Mode 0 interrupts on rising edge if polarity 1, falling if 0.
// RL4: Mode 1 interrupts on both edges regardless of polarity; resets 0.
// RL5: Bit 11 picks supply: 0 interface supply, 1 always-on supply; resets 0.
// RL6: Bit 10 polarity: 0 inverted active low, 1 active high; resets 1. Clock outputs (codes 1 and 14) are never inverted.
// RL7: Bit 9 drive: 0 push-pull, 1 open drain; resets 0.
// RL8: Bit 7 low tri-states the pin; high is normal; resets 0.
// RL9: Four-bit function field at 3:0 resets to 0000, meaning depends on direction.
// RL10: Input codes 0 and 1 are plain input with and without long debounce.
// RL11: Input codes 2 to 6 are power, sleep and wake requests.
// RL12: Input code 7 is watchdog reset, codes 8 and 9 voltage-scaling selects.
// RL13: Input codes 10-13 hardware enables and controls, 14-15 controls debounced.
// RL14: Output code 0 plain output, code 1 the 32.768kHz oscillator clock.
// RL15: Output codes 2, 3, 4 show ON, SLEEP, state change; 5-7 reserved.
// RL16: Output codes 8 and 9 show buck one and two voltage change done.
// RL17: Output codes 10-11 power enables, 12 supply good, 13 power good.
// RL18: Output code 14 drives 2MHz power clock, 15 auxiliary reset. The divider gives about 2.016 MHz.
// RL19: Direction bit chooses input or output decoding of the function code.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "gpio7_pin_map.vh"

module gpio7_pin_control #(
	parameter LONG_DEBOUNCE = `LONG_DEBOUNCE_CYCLES
) (
	input wire mclk,
	input wire srst,
	input wire clk_en,
	input wire [15:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	output wire irq,
	input wire pin_in,
	output wire pin_out,
	output wire pin_oe,
	output wire [1:0] pull_resistor_select,
	output wire supply_domain_select,
	input wire osc32_clk,
	input wire on_state,
	input wire sleep_state,
	input wire state_change,
	input wire dvs_done_one,
	input wire dvs_done_two,
	input wire ext_pwr_enable_one,
	input wire ext_pwr_enable_two,
	input wire system_supply_good,
	input wire converter_power_good,
	input wire aux_reset,
	output reg power_onoff_req,
	output reg sleep_wake_req,
	output reg sleep_req,
	output reg power_on_req,
	output reg watchdog_reset,
	output reg voltage_scaling_select_one,
	output reg voltage_scaling_select_two,
	output reg [1:0] hw_enable,
	output reg [1:0] hw_control,
	output reg gpio_in_value
);

	localparam DB_W = 17;
	// Counter is 17 bits wide; a debounce above 131071 cycles needs it widened
	localparam [DB_W-1:0] DB_MAX = LONG_DEBOUNCE[DB_W-1:0];
	localparam integer PCLK_HALF_I = `PWRCLK_HALF;
	localparam [5:0] PCLK_HALF = PCLK_HALF_I[5:0];

	reg [15:0] config_r;
	reg [`IRQ_WIDTH-1:0] irq_status_r;
	reg [`IRQ_WIDTH-1:0] irq_mask_r;
	reg out_value_r;
	reg [2:0] pin_sync_r;
	reg pin_stable_r;
	reg pin_long_r;
	reg [DB_W-1:0] db_cnt_r;
	reg [2:0] osc_sync_r;
	reg [5:0] pclk_cnt_r;
	reg pclk_r;
	reg level_prev_r;
	reg [`IRQ_WIDTH-1:0] irq_set;
	reg drive_level;
	reg osc_stable_r;
	reg [15:0] rdata_nxt;

	// ****************************************
	// Configuration fields
	// ****************************************

	wire pin_direction = config_r[`DIR_BIT];
	wire irq_edge_mode = config_r[`IRQ_MODE_BIT];
	wire polarity_select = config_r[`POL_BIT];
	wire open_drain_select = config_r[`OD_BIT];
	wire pin_enable = config_r[`ENA_BIT];
	wire [3:0] pin_function = config_r[`FN_HI:`FN_LO];

	// ****************************************
	// Helpers
	// ****************************************
	// Long debounce codes: plain input 0, sleep/wake 4, controls 14 and 15
	function uses_long;
		input [3:0] fn;
		begin
			uses_long = (fn == 4'h0) || (fn == 4'h4) || (fn == 4'hE) || (fn == 4'hF);
		end
	endfunction

	function is_fn;
		input [3:0] fn;
		input [3:0] code;
		begin
			is_fn = (fn == code);
		end
	endfunction

	// ****************************************
	// Input route decode
	// ****************************************
	// One-hot pick of the internal input that a function code feeds
	function [10:0] in_route;
		input [3:0] fn;
		begin
			in_route = 11'h000;
			case (fn)
				4'h2: in_route[0] = 1'b1;
				4'h3: in_route[1] = 1'b1;
				4'h4: in_route[1] = 1'b1;
				4'h5: in_route[2] = 1'b1;
				4'h6: in_route[3] = 1'b1;
				4'h7: in_route[4] = 1'b1;
				4'h8: in_route[5] = 1'b1;
				4'h9: in_route[6] = 1'b1;
				4'hA: in_route[7] = 1'b1;
				4'hB: in_route[8] = 1'b1;
				4'hC: in_route[9] = 1'b1;
				4'hD: in_route[10] = 1'b1;
				4'hE: in_route[9] = 1'b1;
				4'hF: in_route[10] = 1'b1;
				default: in_route = 11'h000;
			endcase
		end
	endfunction

	// Reserved pull code 11 is passed on as written; the pad decides
	assign pull_resistor_select = config_r[`PULL_HI:`PULL_LO]; // RL2
	assign supply_domain_select = config_r[`DOMAIN_BIT]; // RL5

	// ****************************************
	// Register port
	// ****************************************
	always @(posedge mclk) begin
		if (srst) begin
			config_r <= `CONFIG_RESET; // RL1 RL2 RL4 RL5 RL6 RL7 RL8 RL9
			irq_mask_r <= {`IRQ_WIDTH{1'b0}};
			out_value_r <= 1'b0;
			reg_rdata <= 16'h0000;
		end else if (clk_en) begin
			if (reg_wr) begin
				case (reg_addr)
					`GPIO7_PIN_CONFIG_ADDR: config_r <= reg_wdata & `CONFIG_WMASK;
					`IRQ_MASK_ADDR: irq_mask_r <= reg_wdata[`IRQ_WIDTH-1:0];
					`OUT_VALUE_ADDR: out_value_r <= reg_wdata[0];
					default: ;
				endcase
			end
			reg_rdata <= rdata_nxt;
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	// Zero outside the read slot, so a stale word is never taken as an answer
	always @* begin
		rdata_nxt = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				`GPIO7_PIN_CONFIG_ADDR: rdata_nxt = config_r;
				`IRQ_STATUS_ADDR: rdata_nxt = {14'h0000, irq_status_r};
				`IRQ_MASK_ADDR: rdata_nxt = {14'h0000, irq_mask_r};
				`PIN_STATE_ADDR: rdata_nxt = {14'h0000, pin_long_r, pin_stable_r};
				`OUT_VALUE_ADDR: rdata_nxt = {15'h0000, out_value_r};
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	// ****************************************
	// Pin input conditioning
	// ****************************************
	// Change accepted when the second and third stages agree
	always @(posedge mclk) begin
		if (srst) begin
			pin_sync_r <= 3'h0;
			pin_stable_r <= 1'b0;
			osc_sync_r <= 3'h0;
			osc_stable_r <= 1'b0;
		end else if (clk_en) begin
			pin_sync_r <= {pin_sync_r[1:0], pin_in};
			osc_sync_r <= {osc_sync_r[1:0], osc32_clk};
			if (pin_sync_r[1] == pin_sync_r[2])
				pin_stable_r <= pin_sync_r[2];
			// Oscillator also waits for agreement, so no half-settled sample leaves
			if (osc_sync_r[1] == osc_sync_r[2])
				osc_stable_r <= osc_sync_r[2];
		end
	end

	// Long filter: level must hold for the whole count before it is taken
	always @(posedge mclk) begin
		if (srst) begin
			db_cnt_r <= {DB_W{1'b0}};
			pin_long_r <= 1'b0;
		end else if (clk_en) begin
			if (pin_stable_r == pin_long_r) begin
				db_cnt_r <= {DB_W{1'b0}};
			end else if (db_cnt_r >= DB_MAX - 1'b1) begin
				db_cnt_r <= {DB_W{1'b0}};
				pin_long_r <= pin_stable_r;
			end else begin
				db_cnt_r <= db_cnt_r + 1'b1;
			end
		end
	end

	// Logical level after polarity; inverted pin is active low
	wire raw_sel = uses_long(pin_function) ? pin_long_r : pin_stable_r; // RL10
	wire level = polarity_select ? raw_sel : ~raw_sel; // RL6
	wire in_active = pin_direction & pin_enable; // RL8 RL19
	wire [10:0] in_sel = in_active ? in_route(pin_function) : 11'h000; // RL19

	// ****************************************
	// Input function routing
	// ****************************************
	always @(posedge mclk) begin
		if (srst) begin
			power_onoff_req <= 1'b0;
			sleep_wake_req <= 1'b0;
			sleep_req <= 1'b0;
			power_on_req <= 1'b0;
			watchdog_reset <= 1'b0;
			voltage_scaling_select_one <= 1'b0;
			voltage_scaling_select_two <= 1'b0;
			hw_enable <= 2'h0;
			hw_control <= 2'h0;
			gpio_in_value <= 1'b0;
		end else if (clk_en) begin
			gpio_in_value <= level;
			power_onoff_req <= in_sel[0] & level; // RL11
			sleep_wake_req <= in_sel[1] & level; // RL11
			sleep_req <= in_sel[2] & level; // RL11
			power_on_req <= in_sel[3] & level; // RL11
			watchdog_reset <= in_sel[4] & level; // RL12
			voltage_scaling_select_one <= in_sel[5] & level; // RL12
			voltage_scaling_select_two <= in_sel[6] & level; // RL12
			hw_enable[0] <= in_sel[7] & level; // RL13
			hw_enable[1] <= in_sel[8] & level; // RL13
			hw_control[0] <= in_sel[9] & level; // RL13
			hw_control[1] <= in_sel[10] & level; // RL13
		end
	end

	// ****************************************
	// Edge interrupt
	// ****************************************
	wire rise = level & ~level_prev_r;
	wire fall = ~level & level_prev_r;
	// Level already carries polarity, so a rising raw edge with polarity 1
	// and a falling raw edge with polarity 0 both appear as a logical rise
	wire edge_hit = irq_edge_mode ? (rise | fall) : rise; // RL3 RL4

	always @* begin
		irq_set = {`IRQ_WIDTH{1'b0}};
		irq_set[`IRQ_EDGE_BIT] = in_active & edge_hit;
		irq_set[`IRQ_WDOG_BIT] = in_active & is_fn(pin_function, 4'h7) & rise;
	end

	// Previous level resets to the idle logical level, so no false edge
	always @(posedge mclk) begin
		if (srst)
			level_prev_r <= 1'b0;
		else if (clk_en)
			level_prev_r <= level;
	end

	// ****************************************
	// Interrupt status
	// ****************************************
	wire status_wr = reg_wr & (reg_addr == `IRQ_STATUS_ADDR);

	// One sticky bit per event; set wins over a write-one clear in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1) begin : g_status
			always @(posedge mclk) begin
				if (srst)
					irq_status_r[gi] <= 1'b0;
				else if (clk_en)
					irq_status_r[gi] <= irq_set[gi]
						| (irq_status_r[gi] & ~(status_wr & reg_wdata[gi]));
			end
		end
	endgenerate

	assign irq = |(irq_status_r & irq_mask_r);

	// ****************************************
	// Power clock divider
	// ****************************************
	// About 2.016 MHz; an exact 2 MHz cannot be divided from 125 MHz
	always @(posedge mclk) begin
		if (srst) begin
			pclk_cnt_r <= 6'h00;
			pclk_r <= 1'b0;
		end else if (clk_en) begin
			if (pclk_cnt_r >= PCLK_HALF - 1'b1) begin
				pclk_cnt_r <= 6'h00;
				pclk_r <= ~pclk_r; // RL18
			end else begin
				pclk_cnt_r <= pclk_cnt_r + 1'b1;
			end
		end
	end

	// ****************************************
	// Output function routing
	// ****************************************
	always @* begin
		case (pin_function) // RL19
			4'h0: drive_level = out_value_r; // RL14
			4'h1: drive_level = osc_stable_r; // RL14
			4'h2: drive_level = on_state; // RL15
			4'h3: drive_level = sleep_state; // RL15
			4'h4: drive_level = state_change; // RL15
			4'h8: drive_level = dvs_done_one; // RL16
			4'h9: drive_level = dvs_done_two; // RL16
			4'hA: drive_level = ext_pwr_enable_one; // RL17
			4'hB: drive_level = ext_pwr_enable_two; // RL17
			4'hC: drive_level = system_supply_good; // RL17
			4'hD: drive_level = converter_power_good; // RL17
			4'hE: drive_level = pclk_r; // RL18
			4'hF: drive_level = aux_reset; // RL18
			default: drive_level = 1'b0; // RL15
		endcase
	end

	// ****************************************
	// Pin drive
	// ****************************************
	// Clocks are not inverted so that the frequency stays true
	wire clk_fn = is_fn(pin_function, 4'h1) | is_fn(pin_function, 4'hE);
	wire out_bit = (polarity_select | clk_fn) ? drive_level : ~drive_level; // RL6

	reg out_bit_r;
	always @(posedge mclk) begin
		if (srst)
			out_bit_r <= 1'b0;
		else if (clk_en)
			out_bit_r <= out_bit;
	end

	wire out_active = ~pin_direction & pin_enable; // RL1 RL8
	assign pin_out = open_drain_select ? 1'b0 : out_bit_r; // RL7
	// Open drain only sinks; releases for a high level
	assign pin_oe = out_active & (open_drain_select ? ~out_bit_r : 1'b1); // RL7

endmodule

// ### verification/gpio7_pin_control_asserts.sv
// Purpose: Port assertions for the pin control block
// Assumes: One clock, srst synchronous
// Notes: Config state is inferred from writes
`timescale 1ns/1ps
`include "gpio7_pin_map.vh"
module gpio7_pin_chk (
	input wire mclk,
	input wire srst,
	input wire clk_en,
	input wire [15:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	input wire irq,
	input wire pin_out,
	input wire pin_oe,
	input wire [1:0] pull_resistor_select,
	input wire supply_domain_select
);
	// ****
	// Properties
	// ****
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);
	sequence cfg_wr;
		reg_wr && clk_en && reg_addr == `GPIO7_PIN_CONFIG_ADDR;
	endsequence
	chk_reset_vals: assert property (disable iff (1'b0) srst |=> !pin_oe && !irq &&
		pull_resistor_select == `PULL_DOWN && !supply_domain_select)
		else $error("reset state wrong");
	chk_pull_write: assert property (cfg_wr |=>
		{pull_resistor_select, supply_domain_select} == $past({reg_wdata[14:13], reg_wdata[11]}))
		else $error("pull or domain not updated");
	chk_rdata_idle: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd) && $past(clk_en))
		else $error("read data outside read slot");
	chk_cfg_holes: assert property (reg_rd && clk_en && reg_addr == `GPIO7_PIN_CONFIG_ADDR |=>
		(reg_rdata & ~(`CONFIG_WMASK)) == 16'h0000) else $error("unused bits read nonzero");
	chk_unmapped_rd: assert property (reg_rd && clk_en && reg_addr == 16'h0000 |=>
		reg_rdata == 16'h0000) else $error("unmapped read nonzero");
	chk_oe_off: assert property (cfg_wr ##0 (!reg_wdata[7] || reg_wdata[15]) |-> ##2 !pin_oe)
		else $error("pin driven while off or input");
	chk_od_drive: assert property (cfg_wr ##0 (reg_wdata[9] && !reg_wdata[15]) |->
		##2 (!pin_oe || !pin_out)) else $error("open drain drove high");
	chk_mask_off: assert property (reg_wr && clk_en && reg_addr == `IRQ_MASK_ADDR &&
		reg_wdata[1:0] == 2'h0 |-> ##2 !irq) else $error("masked interrupt raised");
	chk_irq_sticky: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
		else $error("interrupt dropped without write");
endmodule
bind gpio7_pin_control gpio7_pin_chk u_chk (.mclk, .srst, .clk_en, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .irq, .pin_out, .pin_oe, .pull_resistor_select,
	.supply_domain_select);

// ### verification/pin_partner.sv
// Purpose: Far-side logic on the pin
// Assumes: Bench chooses when to drive
// Notes: Unpulled idle pin flips each cycle
`timescale 1ns/1ps
module pin_partner (
	input wire mclk,
	input wire pin_out,
	input wire pin_oe,
	input wire [1:0] pull_resistor_select,
	input wire drive_en,
	input wire drive_val,
	output logic pin_level
);
	logic float_r = 1'b0;
	always @(posedge mclk) begin
		float_r <= ~pin_level;
	end
	always_comb begin
		if (pin_oe)
			pin_level = pin_out;
		else if (drive_en)
			pin_level = drive_val;
		else if (pull_resistor_select == 2'h1)
			pin_level = 1'b0;
		else if (pull_resistor_select == 2'h2)
			pin_level = 1'b1;
		else
			pin_level = float_r;
	end
endmodule

// ### verification/test_gpio7_pin_control.sv
// Purpose: Self-checking bench for the pin control block
// Assumes: Short debounce of 8 cycles
// Notes: Oscillator clock function left unchecked; power clock toggles are counted
`timescale 1ns/1ps
`include "gpio7_pin_map.vh"
module test_gpio7_pin_control;
	logic mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, drv_en = 0, drv_val = 0;
	logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, src = 16'h0000, e;
	wire [15:0] reg_rdata;
	wire [1:0] pull_resistor_select, hw_enable, hw_control;
	wire irq, pin_out, pin_oe, supply_domain_select, pin_level, gpio_in_value, power_onoff_req;
	wire sleep_wake_req, sleep_req, power_on_req, watchdog_reset;
	wire voltage_scaling_select_one, voltage_scaling_select_two;
	wire [11:0] got_in = {gpio_in_value, hw_control, hw_enable, voltage_scaling_select_two,
		voltage_scaling_select_one, watchdog_reset, power_on_req, sleep_req, sleep_wake_req,
		power_onoff_req};
	int bad_count = 0, samples_checked = 0, cycles = 0, m_cfg, c, pol;
	int slot[16] = '{11, 11, 0, 1, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 9, 10};
	gpio7_pin_control #(.LONG_DEBOUNCE(8)) u_dut (.mclk, .srst, .clk_en(1'b1), .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .pin_in(pin_level), .pin_out, .pin_oe,
		.pull_resistor_select, .supply_domain_select, .osc32_clk(1'b0), .on_state(src[2]),
		.sleep_state(src[3]), .state_change(src[4]), .dvs_done_one(src[8]),
		.dvs_done_two(src[9]), .ext_pwr_enable_one(src[10]), .ext_pwr_enable_two(src[11]),
		.system_supply_good(src[12]), .converter_power_good(src[13]), .aux_reset(src[15]),
		.power_onoff_req, .sleep_wake_req, .sleep_req, .power_on_req, .watchdog_reset,
		.voltage_scaling_select_one, .voltage_scaling_select_two, .hw_enable, .hw_control,
		.gpio_in_value);
	pin_partner u_far (.mclk, .pin_out, .pin_oe, .pull_resistor_select, .drive_en(drv_en),
		.drive_val(drv_val), .pin_level);
	initial forever #4 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 8000) begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 cmp(reg_rdata, exp);
	endtask
	task automatic cfgw(input logic [15:0] d);
		m_cfg = d & `CONFIG_WMASK;
		wr(`GPIO7_PIN_CONFIG_ADDR, d);
	endtask
	initial begin
		void'($urandom(5774));
		tick(20);
		srst <= 1'b0;
		m_cfg = (1 << 15) | (1 << 13) | (1 << 10);
		rd(`GPIO7_PIN_CONFIG_ADDR, 16'(m_cfg));
		rd(16'h0000, 16'h0000);
		rd(`IRQ_MASK_ADDR, 16'h0000);
		repeat (6) begin
			cfgw(16'($urandom));
			rd(`GPIO7_PIN_CONFIG_ADDR, 16'(m_cfg));
			cmp({pull_resistor_select, supply_domain_select}, {m_cfg[14:13], m_cfg[11]});
		end
		// ****
		// Output functions, pull-up on the far side
		// ****
		for (c = 0; c < 16; c++) begin
			if (c == 1 || c == 14) continue;
			pol = (c > 4 && c < 8) ? 1 : $urandom_range(1, 0);
			src <= 16'($urandom);
			@(posedge mclk);
			wr(`OUT_VALUE_ADDR, 16'h0000 | src[0]);
			cfgw(16'(32'h4080 | (pol << 10) | (c[0] << 9) | c));
			tick(4);
			e = (c > 4 && c < 8) ? 16'h0000 : 16'(src[c] ^ !pol[0]);
			cmp(pin_level, e);
			cmp(pin_oe, c[0] ? !e[0] : 1'b1);
		end
		cfgw(16'h448E);
		tick(2);
		e = 16'h0000;
		pol = pin_level;
		repeat (124) begin
			tick(1);
			#1 if (pin_level !== pol[0]) e++;
			pol = pin_level;
		end
		cmp(e, 16'(124 / `PWRCLK_HALF));
		cfgw(16'h4000);
		tick(4);
		cmp(pin_oe, 16'h0000);
		// ****
		// Input functions, far side drives
		// ****
		for (c = 0; c < 16; c++) begin
			pol = $urandom_range(1, 0);
			@(posedge mclk);
			drv_en <= 1'b1;
			drv_val <= pol[0];
			cfgw(16'(32'h8080 | (pol << 10) | c));
			tick(24);
			cmp(got_in, 16'(1 << slot[c]) | 16'h0800);
			drv_val <= !pol[0];
			tick(24);
			cmp(got_in, 16'h0000);
		end
		wr(`IRQ_MASK_ADDR, 16'h0001);
		for (c = 0; c < 8; c++) begin
			drv_val <= !c[0];
			cfgw(16'(32'h8081 | (c[1] << 10) | (c[2] << 12)));
			tick(8);
			wr(`IRQ_STATUS_ADDR, 16'h0003);
			drv_val <= c[0];
			tick(8);
			e = 16'(c[2] || (c[0] == c[1]));
			cmp(irq, e);
			rd(`IRQ_STATUS_ADDR, e);
		end
		wr(`IRQ_MASK_ADDR, 16'h0000);
		tick(3);
		cmp(irq, 16'h0000);
		wr(`IRQ_MASK_ADDR, 16'h0001);
		tick(3);
		cmp(irq, 16'h0001);
		wr(`IRQ_STATUS_ADDR, 16'h0001);
		tick(3);
		cmp(irq, 16'h0000);
		wrap_up();
	end
endmodule
